// ---- hw/bkreg_bank.sv ----
// Register bank with its serial bus slave for a step-down regulator
`timescale 1ns/10ps
`include "bkreg_consts.svh"

module bkreg_bank #(
   parameter logic [2:0] VENDOR_CODE   = 3'h2,  // Arbitrary value
   parameter logic [3:0] CHIP_CODE     = 4'hA,  // Arbitrary value
   parameter logic [3:0] REVISION_CODE = 4'h3   // Arbitrary value
) (
   input  wire logic                   core_clk,   // Core clock, 10 MHz
   input  wire logic                   reset,      // Async reset, high
   input  wire logic                   scl,        // Bus clock from host, link clock
   input  wire logic                   sda_in,     // Bus data level
   output logic                        sda_out,    // Bus data drive value (always 0)
   output logic                        sda_oe,     // Pull data low when high
   input  wire logic                   enable_pin, // Hardware enable pin
   input  wire logic                   setting_select_pin, // Voltage select pin
   input  wire logic                   mode_pin,   // Forces fixed frequency when high
   input  wire bkreg_pkg::bkreg_analog_t analog,   // Regulator state, asynchronous
   output bkreg_pkg::bkreg_drive_t     drive       // Settings to the regulation loop
);

   // ***************************************************************
   // Link domain: bus protocol on scl edges
   // ***************************************************************
   // Start and stop are seen as sda edges while scl is high; a small
   // sda-clocked detector marks them and the scl domain consumes them.
   logic start_tgl_reg;
   logic stop_tgl_reg;
   logic start_seen_reg;
   logic stop_seen_reg;

   // Start detect on sda falling, a toggle acknowledged by the next scl rise
   always_ff @(negedge sda_in or posedge reset) begin
      if (reset) begin
         start_tgl_reg <= 1'b0;
      end else if (scl) begin
         start_tgl_reg <= ~start_tgl_reg;
      end
   end

   always_ff @(posedge sda_in or posedge reset) begin
      if (reset) begin
         stop_tgl_reg <= 1'b0;
      end else if (scl) begin
         stop_tgl_reg <= ~stop_tgl_reg;
      end
   end

   // Protocol state in scl domain
   bkreg_pkg::bkreg_state_t state_reg, state_next;
   logic [7:0] shift_reg, shift_next;
   logic [2:0] bit_cnt_reg, bit_cnt_next;
   logic [7:0] ptr_reg, ptr_next;
   logic       rd_mode_reg, rd_mode_next;
   logic       start_ack_reg, start_ack_next;
   logic       stop_ack_reg, stop_ack_next;
   logic       wr_tgl_reg, wr_tgl_next;
   logic [7:0] wr_addr_reg, wr_addr_next;
   logic [7:0] wr_data_reg, wr_data_next;
   logic       rd_tgl_reg, rd_tgl_next;
   logic [7:0] rd_addr_reg, rd_addr_next; // Address of the byte just read
   logic [7:0] tx_reg, tx_next;
   logic       drive_low_reg, drive_low_next;
   logic [7:0] rd_word;          // read value, stable across crossing
   logic       got_start;
   logic       got_stop;

   assign got_start = start_tgl_reg != start_ack_reg;
   assign got_stop  = stop_tgl_reg != stop_ack_reg;

   // Sample on rising scl
   always_comb begin
      state_next    = state_reg;
      shift_next    = shift_reg;
      bit_cnt_next  = bit_cnt_reg;
      ptr_next      = ptr_reg;
      rd_mode_next  = rd_mode_reg;
      start_ack_next = start_tgl_reg;
      stop_ack_next  = stop_tgl_reg;
      wr_tgl_next   = wr_tgl_reg;
      wr_addr_next  = wr_addr_reg;
      wr_data_next  = wr_data_reg;
      rd_tgl_next   = rd_tgl_reg;
      rd_addr_next  = rd_addr_reg;
      if (got_start) begin
         // First bit after a start is address bit 6
         state_next   = bkreg_pkg::BKREG_ADDR;
         shift_next   = {7'h00, sda_in};
         bit_cnt_next = 3'h1;
      end else if (got_stop) begin
         state_next = bkreg_pkg::BKREG_IDLE;
      end else begin
         unique case (state_reg)
            bkreg_pkg::BKREG_IDLE: begin
            end
            bkreg_pkg::BKREG_ADDR, bkreg_pkg::BKREG_REG, bkreg_pkg::BKREG_WDATA: begin
               shift_next   = {shift_reg[6:0], sda_in};
               bit_cnt_next = bit_cnt_reg + 3'h1;
               if (bit_cnt_reg == 3'h7) begin
                  if (state_reg == bkreg_pkg::BKREG_ADDR) begin
                     if (shift_reg[6:0] == `BKREG_BUS_ADDR) begin
                        state_next   = bkreg_pkg::BKREG_ADDR_ACK;
                        rd_mode_next = sda_in;
                     end else begin
                        state_next = bkreg_pkg::BKREG_IDLE;
                     end
                  end else if (state_reg == bkreg_pkg::BKREG_REG) begin
                     state_next = bkreg_pkg::BKREG_REG_ACK;
                     ptr_next   = {shift_reg[6:0], sda_in};
                  end else begin
                     state_next   = bkreg_pkg::BKREG_WDATA_ACK;
                     wr_addr_next = ptr_reg;
                     wr_data_next = {shift_reg[6:0], sda_in};
                     wr_tgl_next  = ~wr_tgl_reg;
                  end
               end
            end
            bkreg_pkg::BKREG_ADDR_ACK: begin
               bit_cnt_next = 3'h0;
               state_next   = rd_mode_reg ? bkreg_pkg::BKREG_RDATA : bkreg_pkg::BKREG_REG;
            end
            bkreg_pkg::BKREG_REG_ACK, bkreg_pkg::BKREG_WDATA_ACK: begin
               bit_cnt_next = 3'h0;
               if (state_reg == bkreg_pkg::BKREG_WDATA_ACK) begin
                  ptr_next = ptr_reg + 8'h01;   // Auto increment on burst
               end
               state_next = bkreg_pkg::BKREG_WDATA;
            end
            bkreg_pkg::BKREG_RDATA: begin
               bit_cnt_next = bit_cnt_reg + 3'h1;
               if (bit_cnt_reg == 3'h7) begin
                  state_next   = bkreg_pkg::BKREG_RDATA_ACK;
                  rd_tgl_next  = ~rd_tgl_reg;  // Read side effects
                  // Pointer moves on at the ack, before the core sees the toggle
                  rd_addr_next = ptr_reg;
               end
            end
            bkreg_pkg::BKREG_RDATA_ACK: begin
               bit_cnt_next = 3'h0;
               ptr_next     = ptr_reg + 8'h01;
               state_next   = sda_in ? bkreg_pkg::BKREG_IDLE : bkreg_pkg::BKREG_RDATA;
            end
         endcase
      end
   end

   always_ff @(posedge scl or posedge reset) begin
      if (reset) begin
         state_reg     <= bkreg_pkg::BKREG_IDLE;
         shift_reg     <= 8'h00;
         bit_cnt_reg   <= 3'h0;
         ptr_reg       <= 8'h00;
         rd_mode_reg   <= 1'b0;
         start_ack_reg <= 1'b0;
         stop_ack_reg  <= 1'b0;
         wr_tgl_reg    <= 1'b0;
         wr_addr_reg   <= 8'h00;
         wr_data_reg   <= 8'h00;
         rd_tgl_reg    <= 1'b0;
         rd_addr_reg   <= 8'h00;
      end else begin
         state_reg     <= state_next;
         shift_reg     <= shift_next;
         bit_cnt_reg   <= bit_cnt_next;
         ptr_reg       <= ptr_next;
         rd_mode_reg   <= rd_mode_next;
         start_ack_reg <= start_ack_next;
         stop_ack_reg  <= stop_ack_next;
         wr_tgl_reg    <= wr_tgl_next;
         wr_addr_reg   <= wr_addr_next;
         wr_data_reg   <= wr_data_next;
         rd_tgl_reg    <= rd_tgl_next;
         rd_addr_reg   <= rd_addr_next;
      end
   end

   // Drive on falling scl: ack slots and read data bits
   always_comb begin
      tx_next        = tx_reg;
      drive_low_next = 1'b0;
      unique case (state_reg)
         bkreg_pkg::BKREG_ADDR_ACK, bkreg_pkg::BKREG_REG_ACK,
         bkreg_pkg::BKREG_WDATA_ACK: begin
            drive_low_next = 1'b1;
            tx_next        = rd_word;   // Preload for a read that follows
         end
         bkreg_pkg::BKREG_RDATA: begin
            drive_low_next = ~tx_reg[~bit_cnt_reg];
         end
         bkreg_pkg::BKREG_RDATA_ACK: begin
            tx_next = rd_word;
         end
         default: begin
         end
      endcase
   end

   always_ff @(negedge scl or posedge reset) begin
      if (reset) begin
         tx_reg        <= 8'h00;
         drive_low_reg <= 1'b0;
      end else begin
         tx_reg        <= tx_next;
         drive_low_reg <= drive_low_next;
      end
   end

   // Open drain: only ever pulls low
   assign sda_out = 1'b0;
   assign sda_oe  = drive_low_reg;

   // ***************************************************************
   // Core domain: crossings from the link
   // ***************************************************************
   logic [2:0] wr_sync_reg;
   logic [2:0] rd_sync_reg;
   logic       wr_event;
   logic       rd_event;
   // Pins and analog status pass two flops before use
   logic [8:0] pin_sync1_reg;
   logic [8:0] pin_sync2_reg;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         wr_sync_reg   <= 3'h0;
         rd_sync_reg   <= 3'h0;
         pin_sync1_reg <= 9'h000;
         pin_sync2_reg <= 9'h000;
      end else begin
         wr_sync_reg   <= {wr_sync_reg[1:0], wr_tgl_reg};
         rd_sync_reg   <= {rd_sync_reg[1:0], rd_tgl_reg};
         pin_sync1_reg <= {enable_pin, setting_select_pin, mode_pin, analog};
         pin_sync2_reg <= pin_sync1_reg;
      end
   end

   // Edge of the synchronised toggle, never the first stage
   assign wr_event = wr_sync_reg[2] ^ wr_sync_reg[1];
   assign rd_event = rd_sync_reg[2] ^ rd_sync_reg[1];

   logic                    en_s;
   logic                    sel_s;
   logic                    mode_s;
   bkreg_pkg::bkreg_analog_t an_s;
   assign {en_s, sel_s, mode_s, an_s} = pin_sync2_reg;

   // ***************************************************************
   // Core domain: registers
   // ***************************************************************
   logic [7:0] set_low_reg, set_low_next;
   logic [7:0] set_high_reg, set_high_next;
   logic [7:0] control_reg, control_next;
   logic       reset_stat_reg, reset_stat_next;
   logic [7:0] monitor;
   logic       running;

   // Write decode, with register-reset taking the setting and control registers home and raising the reset flag
   always_comb begin
      set_low_next    = set_low_reg;
      set_high_next   = set_high_reg;
      control_next    = control_reg;
      reset_stat_next = reset_stat_reg;
      if (rd_event && rd_addr_reg == `BKREG_OFS_MONITOR) begin
         reset_stat_next = 1'b0;
      end
      if (wr_event) begin
         unique case (wr_addr_reg)
            `BKREG_OFS_SET_LOW:  set_low_next  = wr_data_reg;
            `BKREG_OFS_SET_HIGH: set_high_next = wr_data_reg;
            `BKREG_OFS_CONTROL: begin
               if (wr_data_reg[`BKREG_BIT_REG_RESET]) begin
                  set_low_next    = `BKREG_RST_SET_LOW;
                  set_high_next   = `BKREG_RST_SET_HIGH;
                  control_next    = `BKREG_RST_CONTROL;
                  reset_stat_next = 1'b1;
               end else begin
                  control_next = wr_data_reg & `BKREG_MSK_CONTROL_WR;
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         set_low_reg    <= `BKREG_RST_SET_LOW;
         set_high_reg   <= `BKREG_RST_SET_HIGH;
         control_reg    <= `BKREG_RST_CONTROL;
         reset_stat_reg <= 1'b0;
      end else begin
         set_low_reg    <= set_low_next;
         set_high_reg   <= set_high_next;
         control_reg    <= control_next;
         reset_stat_reg <= reset_stat_next;
      end
   end

   // ***************************************************************
   // Regulator control and status
   // ***************************************************************
   // Selected register steers enable and code; the select also picks the control mode bit
   always_comb begin
      logic [7:0] sel_word;
      sel_word = sel_s ? set_high_reg : set_low_reg;
      running  = en_s & sel_word[`BKREG_BIT_SOFT_EN];
      drive.run          = running;
      drive.voltage_code = sel_word[6:0];
      drive.slew_code    = control_reg[6:4];
      drive.forced_pwm   = mode_s | control_reg[sel_s];
      drive.pull_down    = ~running & control_reg[`BKREG_BIT_DISCHARGE];
   end

   // Monitor reflects live state; normal regulation gives 8'h81
   assign monitor = {running & an_s.soft_start_done,
                     an_s.input_low,
                     an_s.input_high,
                     an_s.rising_active,
                     an_s.falling_active,
                     reset_stat_reg,
                     an_s.thermal_shutdown,
                     running};

   // Read mux; link samples it only when the pointer is steady
   always_comb begin
      unique case (ptr_reg)
         `BKREG_OFS_SET_LOW:     rd_word = set_low_reg;
         `BKREG_OFS_SET_HIGH:    rd_word = set_high_reg;
         `BKREG_OFS_CONTROL:     rd_word = control_reg & `BKREG_MSK_CONTROL_WR;
         `BKREG_OFS_VENDOR_ID:   rd_word = {VENDOR_CODE, 1'b0, CHIP_CODE};
         `BKREG_OFS_REVISION_ID: rd_word = {4'h0, REVISION_CODE};
         `BKREG_OFS_MONITOR:     rd_word = monitor;
         default:                rd_word = 8'h00;
      endcase
   end

endmodule : bkreg_bank

// ---- hw/bkreg_consts.svh ----
// Register offsets, field positions, reset values, bus address and voltage constants of the regulator register bank
// What this block does
// - Enable pin low forces off; else selected soft-enable
// - Low-select code bits 6:0, reset 1010100
// - High-select code bits 6:0, reset 1001101
// - Select pin picks register 00 or 01
// - Discharge bit pulls output down while disabled
// - Control bits 6:4 set rising slew
// - Reserved bits always read zero
// - Writing reset bit restores defaults; reads zero
// - Mode bits choose PFM/PWM; ignored if mode pin high
// - Address 03 read-only vendor and chip code
// - Address 04 read-only revision code
// - Monitor bit 7: enabled and soft-start done
// - Monitor bit 6: input under-voltage
// - Monitor bit 5: input over-voltage
// - Monitor bit 4: rising transition or soft-start
// - Monitor bit 3: falling transition or soft-start
// - Monitor bit 2: register reset, cleared by read
// - Monitor bit 1: thermal shutdown active
// - Monitor bit 0: regulator enabled
// - Normal regulation reads monitor 1000 0001
// - Slew codes halve from 64 to 0.5 mV/us
// - Answer only at bus address 60 hex
`ifndef BKREG_CONSTS_SVH
`define BKREG_CONSTS_SVH

// ***************************************************************
// Register map
// ***************************************************************
`define BKREG_OFS_SET_LOW      8'h00
`define BKREG_OFS_SET_HIGH     8'h01
`define BKREG_OFS_CONTROL      8'h02
`define BKREG_OFS_VENDOR_ID    8'h03
`define BKREG_OFS_REVISION_ID  8'h04
`define BKREG_OFS_MONITOR      8'h05

`define BKREG_RST_SET_LOW      8'hD4
`define BKREG_RST_SET_HIGH     8'hCD
`define BKREG_RST_CONTROL      8'h80

// Field positions
`define BKREG_BIT_SOFT_EN      7
`define BKREG_BIT_DISCHARGE    7
`define BKREG_BIT_REG_RESET    2
`define BKREG_MSK_CONTROL_WR   8'hF3
`define BKREG_MSK_ID1_RD       8'hEF
`define BKREG_MSK_ID2_RD       8'h0F

// Bus address, 7 bits
`define BKREG_BUS_ADDR         7'h60

// Voltage formula: millivolts = 1000 + 6.25 * (code - 64)
`define BKREG_VOUT_BASE_UV     1000000
`define BKREG_VOUT_STEP_UV     6250
`define BKREG_VOUT_OFFSET      64

`endif

// ---- hw/bkreg_pkg.sv ----
// Types shared by the regulator register bank
package bkreg_pkg;

   // Regulator analog state reported into the monitor
   typedef struct packed {
      logic soft_start_done;   // soft-start finished
      logic input_low;         // under-voltage lockout
      logic input_high;        // over-voltage protect
      logic rising_active;     // rising transition under way
      logic falling_active;    // falling transition under way
      logic thermal_shutdown;  // thermal protection active
   } bkreg_analog_t;

   // Settings handed to the regulation loop
   typedef struct packed {
      logic       run;          // converter enabled
      logic       forced_pwm;   // 1 forced fixed frequency, 0 auto PFM
      logic       pull_down;    // output discharge active
      logic [6:0] voltage_code; // selected code
      logic [2:0] slew_code;    // rising slew select
   } bkreg_drive_t;

   typedef enum logic [3:0] {
      BKREG_IDLE,
      BKREG_ADDR,
      BKREG_ADDR_ACK,
      BKREG_REG,
      BKREG_REG_ACK,
      BKREG_WDATA,
      BKREG_WDATA_ACK,
      BKREG_RDATA,
      BKREG_RDATA_ACK
   } bkreg_state_t;

endpackage : bkreg_pkg

// ---- tb/bkreg_bank_assertions.sv ----
// Port-level checks of the regulator register bank
`timescale 1ns/10ps

module bkreg_bank_assertions (
   input wire logic                   core_clk,   // Core clock
   input wire logic                   reset,      // Async reset, high
   input wire logic                   scl,        // Bus clock
   input wire logic                   sda_out,    // Data drive value
   input wire logic                   sda_oe,     // Data pull enable
   input wire logic                   enable_pin, // Hardware enable
   input wire logic                   mode_pin,   // Mode pin
   input wire bkreg_pkg::bkreg_drive_t drive      // Loop settings
);
   // *****************************************
   // Pin sequences, three samples cover the two-flop sync
   // *****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   // Data pull seen at the last bus clock rise, for the high-phase check
   logic oe_at_rise_reg;
   always_ff @(posedge scl or posedge reset) begin
      if (reset) begin
         oe_at_rise_reg <= 1'b0;
      end else begin
         oe_at_rise_reg <= sda_oe;
      end
   end

   sequence pin_off_s;
      !enable_pin [*3];
   endsequence
   sequence mode_high_s;
      mode_pin [*3];
   endsequence

   a_pin_forces_off: assert property (pin_off_s |-> !drive.run)
      else $error("Regulator runs with enable pin low");
   a_mode_forces_pwm: assert property (mode_high_s |-> drive.forced_pwm)
      else $error("Mode pin high without forced fixed frequency");
   a_pull_down_off: assert property (drive.run |-> !drive.pull_down)
      else $error("Pull-down active while converter runs");
   a_slew_default: assert property ($fell(reset) |-> drive.slew_code == 3'h0)
      else $error("Slew code not at default after reset");
   a_code_default: assert property ($fell(reset) |->
      (drive.voltage_code == 7'h54 || drive.voltage_code == 7'h4D))
      else $error("Voltage code not at default after reset");
   a_discharge_default: assert property ($fell(reset) |-> drive.pull_down)
      else $error("Discharge not active after reset");
   // Open-drain data only changes while the bus clock is low
   a_oe_rise_low: assert property (@(negedge scl) disable iff (reset)
      sda_oe == oe_at_rise_reg)
      else $error("Data drive changed while bus clock high");
   // Ack plus one read byte is the longest run of pulled bits
   a_oe_hold_high: assert property (@(posedge scl) disable iff (reset)
      sda_oe [*8] |-> ##[1:2] !sda_oe)
      else $error("Data pulled low for too many bits");
   a_drive_zero: assert property (sda_out == 1'b0)
      else $error("Data drive value not low");
endmodule : bkreg_bank_assertions

bind bkreg_bank bkreg_bank_assertions u_chk (
   .core_clk   (core_clk),
   .reset      (reset),
   .scl        (scl),
   .sda_out    (sda_out),
   .sda_oe     (sda_oe),
   .enable_pin (enable_pin),
   .mode_pin   (mode_pin),
   .drive      (drive)
);

// ---- tb/bkreg_bank_tb.sv ----
// Self-checking bench for the regulator register bank
`timescale 1ns/10ps

module bkreg_bank_tb;
   localparam int LIMIT = 20000; // Core cycles, well above the run
   logic                    core_clk;
   logic                    reset;
   logic                    enable_pin;
   logic                    setting_select_pin;
   logic                    mode_pin;
   bkreg_pkg::bkreg_analog_t analog;
   bkreg_pkg::bkreg_drive_t drive;
   logic                    scl;
   logic                    sda_low;
   logic                    sda_out;
   logic                    sda_oe;
   wire                     sda;
   int                      err_count = 0;
   int                      check_count = 0;
   int                      cycles = 0;
   logic [8:0]              r;
   int                      mb [5] = '{6, 5, 4, 3, 1};

   // Open-drain data with pull-up
   assign sda = !(sda_low || (sda_oe && !sda_out));

   bkreg_bank #(
      .VENDOR_CODE   (3'h5), // Arbitrary value
      .CHIP_CODE     (4'h6), // Arbitrary value
      .REVISION_CODE (4'h9)  // Arbitrary value
   ) dut (
      .core_clk           (core_clk),
      .reset              (reset),
      .scl                (scl),
      .sda_in             (sda),
      .sda_out            (sda_out),
      .sda_oe             (sda_oe),
      .enable_pin         (enable_pin),
      .setting_select_pin (setting_select_pin),
      .mode_pin           (mode_pin),
      .analog             (analog),
      .drive              (drive)
   );

   bkreg_host h (
      .scl     (scl),
      .sda_low (sda_low),
      .sda     (sda)
   );

   initial core_clk = 1'b0;
   always #50 core_clk = ~core_clk;

   // *****************************************
   // Checking and bus tasks
   // *****************************************
   task automatic results();
      $display("Checks %0d, mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : results

   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_reg

   task automatic chk_drv(input bkreg_pkg::bkreg_drive_t exp);
      check_count++;
      if (drive !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got %h exp %h", $time, drive, exp);
      end
   endtask : chk_drv

   // One byte that the device must acknowledge
   task automatic put(input logic [7:0] b);
      logic [8:0] rx;
      h.xfer({b, 1'b1}, rx);
      chk_reg({7'h00, rx[0]}, 8'h00);
   endtask : put

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      h.start();
      put({7'h60, 1'b0});
      put(a);
      put(d);
      h.stop();
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      logic [8:0] rx;
      h.start();
      put({7'h60, 1'b0});
      put(a);
      h.start();
      put({7'h60, 1'b1});
      h.xfer(9'h1FF, rx);
      h.stop();
      chk_reg(rx[8:1], exp);
   endtask : rd

   // Pins change off the sampling edge, then pass the sync
   task automatic pins(input logic en, input logic sel, input logic md);
      @(negedge core_clk);
      enable_pin = en;
      setting_select_pin = sel;
      mode_pin = md;
      repeat (4) @(negedge core_clk);
   endtask : pins

   // Hang guard
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         err_count++;
         results();
      end
   end

   // *****************************************
   // Main sequence
   // *****************************************
   initial begin
      reset = 1'b1;
      enable_pin = 1'b0;
      setting_select_pin = 1'b0;
      mode_pin = 1'b0;
      analog = 6'h00;
      repeat (8) @(negedge core_clk);
      reset = 1'b0;
      repeat (4) @(negedge core_clk);
      rd(8'h00, 8'hD4);
      rd(8'h01, 8'hCD);
      rd(8'h02, 8'h80);
      rd(8'h03, 8'hA6);
      rd(8'h04, 8'h09);
      rd(8'h05, 8'h00);
      // Foreign address left unanswered
      h.start();
      h.xfer({7'h61, 1'b0, 1'b1}, r);
      h.stop();
      chk_reg({7'h00, r[0]}, 8'h01);
      wr(8'h03, 8'hFF);
      rd(8'h03, 8'hA6);
      wr(8'h04, 8'hFF);
      rd(8'h04, 8'h09);
      wr(8'h02, 8'h7B);
      rd(8'h02, 8'h73);
      wr(8'h00, 8'h85);
      wr(8'h01, 8'h3A);
      // Setting selection, enables and modes
      pins(1'b1, 1'b0, 1'b0);
      chk_drv({1'b1, 1'b1, 1'b0, 7'h05, 3'h7});
      wr(8'h02, 8'h72);
      chk_drv({1'b1, 1'b0, 1'b0, 7'h05, 3'h7});
      pins(1'b1, 1'b0, 1'b1);
      chk_drv({1'b1, 1'b1, 1'b0, 7'h05, 3'h7});
      pins(1'b1, 1'b1, 1'b0);
      chk_drv({1'b0, 1'b1, 1'b0, 7'h3A, 3'h7});
      wr(8'h02, 8'hF2);
      chk_drv({1'b0, 1'b1, 1'b1, 7'h3A, 3'h7});
      pins(1'b0, 1'b0, 1'b0);
      chk_drv({1'b0, 1'b0, 1'b1, 7'h05, 3'h7});
      pins(1'b1, 1'b0, 1'b0);
      chk_drv({1'b1, 1'b0, 1'b0, 7'h05, 3'h7});
      // Monitor flags, one condition at a time
      analog = 6'h20;
      repeat (4) @(negedge core_clk);
      rd(8'h05, 8'h81);
      for (int i = 0; i < 5; i++) begin
         @(negedge core_clk);
         analog = {1'b1, 5'h10 >> i};
         repeat (4) @(negedge core_clk);
         rd(8'h05, 8'h81 | (8'h01 << mb[i]));
      end
      @(negedge core_clk);
      analog = 6'h20;
      // Register reset and its read-cleared flag
      wr(8'h02, 8'h04);
      rd(8'h02, 8'h80);
      rd(8'h00, 8'hD4);
      rd(8'h05, 8'h85);
      rd(8'h05, 8'h81);
      results();
   end
endmodule : bkreg_bank_tb

// ---- tb/bkreg_host.sv ----
// Serial bus host model for the regulator register bank
`timescale 1ns/10ps

module bkreg_host (
   output logic      scl,     // Bus clock, still and high when idle
   output logic      sda_low, // Pulls data low when high
   input  wire logic sda      // Resolved data level
);
   // *****************************************
   // Bit timing
   // *****************************************
   localparam realtime Q   = 31.25; // Quarter of the 125 ns bus period
   localparam realtime GAP = 500.0; // Clock held low so the write crosses to the core

   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   // Start or repeated start: data falls while clock is high
   task automatic start();
      sda_low = 1'b0;
      #(Q);
      scl = 1'b1;
      #(Q);
      sda_low = 1'b1;
      #(Q);
      scl = 1'b0;
   endtask : start

   // Nine bits MSB first, each sampled at the clock rise
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         #(Q);
         sda_low = !tx[i];
         #(Q);
         scl = 1'b1;
         rx[i] = sda;
         #(2 * Q);
         scl = 1'b0;
      end
      #(Q);
      sda_low = 1'b0;
      #(GAP);
   endtask : xfer

   // Stop: data rises while clock is high
   task automatic stop();
      sda_low = 1'b1;
      #(Q);
      scl = 1'b1;
      #(Q);
      sda_low = 1'b0;
      #(2 * Q);
   endtask : stop
endmodule : bkreg_host
